// file: chf_pkg.sv
// What this block does
// - ge mode: reaching compare value sets output and arms hysteresis
// - armed hysteresis stops the compare result from being set again until the window is left
// - after leaving the window, rearm only when the condition is newly met
// - ge mode window exit: output follows count >= compare
// - armed ge mode: drop clears output, return does not set it again
// - pulse mode, zero duration: equality sets output, window exit clears it
// - pulse mode, nonzero duration: equality pulses, arms, stores direction
// - no further pulse while inside the armed window
// - exit against stored direction pulses once and disarms
// - exit along stored direction disarms without a pulse
// - frequency mode counts pulses per interval and converts them
// - integration time 10 to 10000 ms in 1 ms steps, config or job
// - frequency result refreshes only when an interval completes
// - no rising edge within an interval reports zero
// - frequency result is given in millihertz
// - frequency mode disables ordinary counting on the channel
// - frequency mode measures the B input
// - end of measurement interrupt on every completed interval when enabled
// - interrupt choice none, process, or diagnostic plus process; diagnostic only for lost interrupt
// - frequency gate equals the software gate bit ANDed with frequency mode
// - hysteresis 0 to 255, settings 0 and 1 disable it
// - pulse duration 0 to 510 ms in 2 ms steps from output assertion
package chf_pkg;
  localparam int unsigned CLK_FREQ_HZ       = 40_000_000;
  localparam int unsigned TICK_TIME_MS      = 1;
  localparam int unsigned TICK_CYCLES       = CLK_FREQ_HZ / 1000 * TICK_TIME_MS;
  localparam int unsigned PULSE_STEP_MS     = 2;
  localparam int unsigned PULSE_STEP_CYCLES = CLK_FREQ_HZ / 1000 * PULSE_STEP_MS;
  localparam int          CNT_W             = 32;
  localparam int          INTEG_W           = 14;
  localparam int          HYST_W            = 8;
  localparam int          PDUR_W            = 8;
  localparam int          SCALE_W           = 20;
  localparam logic [13:0] INTEG_MIN_MS      = 14'h000A;
  localparam logic [13:0] INTEG_MAX_MS      = 14'h2710;
  localparam logic [7:0]  HYST_MIN_ACTIVE   = 8'h02;
  localparam logic [19:0] MHZ_SCALE         = 20'hF4240;
  localparam logic [31:0] COUNT_RST         = 32'h0000_0000;
  localparam logic [31:0] MEAS_RST          = 32'h0000_0000;
  localparam logic [15:0] JOB_NOP           = 16'h0000;
  localparam logic [15:0] JOB_WR_INTEG      = 16'h0004;
  localparam logic [15:0] JOB_RD_INTEG      = 16'h0084;
  localparam logic [15:0] STAT_OK           = 16'h0000;
  localparam logic [15:0] STAT_INTEG_LOW    = 16'h0221;
  localparam logic [15:0] STAT_INTEG_HIGH   = 16'h0222;
  localparam logic [15:0] STAT_BAD_JOB      = 16'h02FF;

  typedef enum logic [1:0] {
    CMP_NONE  = 2'b00,
    CMP_GE    = 2'b01,
    CMP_LE    = 2'b10,
    CMP_PULSE = 2'b11
  } chf_cmp_mode_t;

  typedef enum logic [1:0] {
    IRQ_NONE      = 2'b00,
    IRQ_PROC      = 2'b01,
    IRQ_DIAG_PROC = 2'b10
  } chf_irq_sel_t;

  typedef enum logic {
    HYS_IDLE  = 1'b0,
    HYS_ARMED = 1'b1
  } chf_hys_state_t;

  typedef enum logic {
    FM_IDLE    = 1'b0,
    FM_MEASURE = 1'b1
  } chf_fm_state_t;
endpackage

// file: chf_mhz_div.sv
`timescale 1ns/1ps
module chf_mhz_div
  import chf_pkg::*;
#(
  parameter int CW = CNT_W,
  parameter int DW = INTEG_W
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          start,
  input  wire logic [CW-1:0] pulses,
  input  wire logic [DW-1:0] ms,
  output logic               done,
  output logic [CW-1:0]      quot
);
  localparam int NW = CW + SCALE_W;
  localparam int BW = $clog2(NW + 1);

  logic [DW-1:0] rem_r;
  logic [DW-1:0] ms_r;
  logic [NW-1:0] num_r;
  logic [NW-1:0] quo_r;
  logic [BW-1:0] bit_r;
  logic          busy_r;
  logic          done_r;
  logic [CW-1:0] quot_r;
  logic [DW:0]   shifted;
  logic          qbit;
  logic [DW-1:0] rem_nxt;
  logic [NW-1:0] quo_nxt;
  logic          sat;

  // restoring division, one quotient bit per cycle
  assign shifted = {rem_r, num_r[NW-1]};
  assign qbit    = shifted >= {1'b0, ms_r};
  assign rem_nxt = qbit ? DW'(shifted - {1'b0, ms_r}) : shifted[DW-1:0];
  assign quo_nxt = {quo_r[NW-2:0], qbit};
  assign sat     = |quo_nxt[NW-1:CW];
  assign done    = done_r;
  assign quot    = quot_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rem_r  <= '0;
      ms_r   <= '0;
      num_r  <= '0;
      quo_r  <= '0;
      bit_r  <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      quot_r <= '0;
    end else begin
      done_r <= 1'b0;
      if (start && !busy_r) begin
        rem_r  <= '0;
        ms_r   <= ms;
        num_r  <= NW'(pulses) * NW'(MHZ_SCALE);
        quo_r  <= '0;
        bit_r  <= BW'(NW);
        busy_r <= 1'b1;
      end else if (busy_r) begin
        rem_r <= rem_nxt;
        num_r <= {num_r[NW-2:0], 1'b0};
        quo_r <= quo_nxt;
        bit_r <= bit_r - 1'b1;
        if (bit_r == BW'(1)) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
          // zero pulses divide to zero; huge counts saturate
          quot_r <= sat ? '1 : quo_nxt[CW-1:0];
        end
      end
    end
  end
endmodule // chf_mhz_div

// file: chf_counter_channel.sv
`timescale 1ns/1ps
module chf_counter_channel
  import chf_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYCLES,
  parameter int unsigned STEP_CYC = PULSE_STEP_CYCLES
) (
  // clock and reset
  input  wire logic               REF_CLK_IN,
  input  wire logic               RESET_N_IN,
  // field pins
  input  wire logic               CH_A_IN,
  input  wire logic               CH_B_IN,
  // mode and comparator setup
  input  wire logic               FREQ_MODE_IN,
  input  wire logic [1:0]         CMP_MODE_IN,
  input  wire logic [CNT_W-1:0]   CMP_VALUE_IN,
  input  wire logic [HYST_W-1:0]  HYST_IN,
  input  wire logic [PDUR_W-1:0]  PULSE_DUR_IN,
  // frequency meter control
  input  wire logic               SOFTWARE_GATE_BIT_IN,
  input  wire logic [INTEG_W-1:0] INTEG_CFG_IN,
  input  wire logic               EOM_IRQ_EN_IN,
  input  wire logic [1:0]         IRQ_SEL_IN,
  input  wire logic               IRQ_ACK_IN,
  // job interface
  input  wire logic               JOB_REQ_IN,
  input  wire logic [15:0]        JOB_ID_IN,
  input  wire logic [31:0]        JOB_VAL_IN,
  output logic                    JOB_DONE_OUT,
  output logic                    JOB_ERR_OUT,
  output logic [15:0]             JOB_STAT_OUT,
  output logic [31:0]             JOB_OVAL_OUT,
  // status and results
  output logic                    COMPARE_OUT,
  output logic [CNT_W-1:0]        COUNT_VALUE_OUT,
  output logic                    GATE_STATUS_OUT,
  output logic [CNT_W-1:0]        MEASURED_FREQUENCY_VALUE_OUT,
  output logic                    HW_IRQ_OUT,
  output logic                    DIAG_IRQ_OUT
);
  localparam int TW = $clog2(TICK_CYC + 1);
  localparam int SW = $clog2(STEP_CYC + 1);

  // divider needs about 53 cycles; the shortest interval must outlast it
  if (TICK_CYC * 10 < 64 || STEP_CYC < 1) begin : g_chk
    $error("tick counts too small for the divider");
  end

  //--------------------------------------------------------------------
  // pin synchronisers
  //--------------------------------------------------------------------
  logic [1:0] a_sync_r;
  logic [1:0] b_sync_r;
  logic       a_prev_r;
  logic       b_prev_r;
  logic       a_rise;
  logic       b_rise;

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      a_sync_r <= 2'h0;
      b_sync_r <= 2'h0;
      a_prev_r <= 1'b0;
      b_prev_r <= 1'b0;
    end else begin
      a_sync_r <= {a_sync_r[0], CH_A_IN};
      b_sync_r <= {b_sync_r[0], CH_B_IN};
      a_prev_r <= a_sync_r[1];
      b_prev_r <= b_sync_r[1];
    end
  end

  assign a_rise = a_sync_r[1] & ~a_prev_r;
  assign b_rise = b_sync_r[1] & ~b_prev_r;

  //--------------------------------------------------------------------
  // ordinary counter
  //--------------------------------------------------------------------
  logic [CNT_W-1:0] count_r;
  logic             dir_up_r;
  logic             cnt_step;

  // counting stops entirely while the channel measures frequency
  assign cnt_step = a_rise & SOFTWARE_GATE_BIT_IN & ~FREQ_MODE_IN;

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      count_r  <= COUNT_RST;
      dir_up_r <= 1'b1;
    end else if (cnt_step) begin
      count_r  <= b_sync_r[1] ? count_r + 1'b1 : count_r - 1'b1;
      dir_up_r <= b_sync_r[1];
    end
  end

  assign COUNT_VALUE_OUT = count_r;

  //--------------------------------------------------------------------
  // comparator with hysteresis
  //--------------------------------------------------------------------
  chf_cmp_mode_t  cmp_mode;
  chf_hys_state_t hys_r;
  chf_hys_state_t hys_nxt;
  logic [HYST_W-1:0] hlat_r;
  logic [HYST_W-1:0] hlat_nxt;
  logic              dir_st_r;
  logic              dir_st_nxt;
  logic              out_r;
  logic              out_nxt;
  logic              cond_prev_r;
  logic              fire;
  logic signed [CNT_W-1:0] cnt_s;
  logic signed [CNT_W-1:0] cmp_s;
  logic signed [CNT_W:0]   win_lo;
  logic signed [CNT_W:0]   win_hi;
  logic cond_ge;
  logic cond_le;
  logic cond_eq;
  logic cond;
  logic cond_rise;
  logic hyst_en;
  logic exit_hi;
  logic exit_lo;
  logic win_exit;
  logic pdur_zero;
  logic pulse_on;

  assign cmp_mode  = chf_cmp_mode_t'(CMP_MODE_IN);
  assign cnt_s     = count_r;
  assign cmp_s     = CMP_VALUE_IN;
  assign cond_ge   = cnt_s >= cmp_s;
  assign cond_le   = cnt_s <= cmp_s;
  assign cond_eq   = cnt_s == cmp_s;
  assign cond      = (cmp_mode == CMP_GE) ? cond_ge :
                     (cmp_mode == CMP_LE) ? cond_le : cond_eq;
  assign cond_rise = cond & ~cond_prev_r;
  assign hyst_en   = HYST_IN >= HYST_MIN_ACTIVE;
  // window uses the width latched at arming; a new width waits for the next arm
  assign win_lo    = cmp_s - $signed({1'b0, hlat_r});
  assign win_hi    = cmp_s + $signed({1'b0, hlat_r});
  assign exit_hi   = cnt_s > win_hi;
  assign exit_lo   = cnt_s < win_lo;
  assign win_exit  = exit_hi | exit_lo;
  assign pdur_zero = PULSE_DUR_IN == '0;

  always_comb begin
    hys_nxt    = hys_r;
    hlat_nxt   = hlat_r;
    dir_st_nxt = dir_st_r;
    out_nxt    = 1'b0;
    fire       = 1'b0;
    if (FREQ_MODE_IN || cmp_mode == CMP_NONE) begin
      hys_nxt = HYS_IDLE;
    end else if (cmp_mode != CMP_PULSE) begin
      unique case (hys_r)
        HYS_IDLE: begin
          out_nxt = cond;
          if (cond_rise && hyst_en) begin
            hys_nxt  = HYS_ARMED;
            hlat_nxt = HYST_IN;
          end
        end
        HYS_ARMED: begin
          if (win_exit) begin
            hys_nxt = HYS_IDLE;
            out_nxt = cond;
          end else begin
            out_nxt = out_r & cond;
          end
        end
      endcase
    end else if (pdur_zero) begin
      unique case (hys_r)
        HYS_IDLE: begin
          out_nxt = cond_eq;
          if (cond_rise && hyst_en) begin
            hys_nxt  = HYS_ARMED;
            hlat_nxt = HYST_IN;
          end
        end
        HYS_ARMED: begin
          out_nxt = ~win_exit;
          if (win_exit) begin
            hys_nxt = HYS_IDLE;
          end
        end
      endcase
    end else begin
      unique case (hys_r)
        HYS_IDLE: begin
          if (cond_rise) begin
            fire = 1'b1;
            if (hyst_en) begin
              hys_nxt    = HYS_ARMED;
              hlat_nxt   = HYST_IN;
              dir_st_nxt = dir_up_r;
            end
          end
        end
        HYS_ARMED: begin
          // equality inside the window fires nothing
          if (win_exit) begin
            hys_nxt = HYS_IDLE;
            fire    = exit_hi != dir_st_r;
          end
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      hys_r       <= HYS_IDLE;
      hlat_r      <= '0;
      dir_st_r    <= 1'b1;
      out_r       <= 1'b0;
      cond_prev_r <= 1'b0;
    end else begin
      hys_r       <= hys_nxt;
      hlat_r      <= hlat_nxt;
      dir_st_r    <= dir_st_nxt;
      out_r       <= out_nxt;
      cond_prev_r <= cond;
    end
  end

  //--------------------------------------------------------------------
  // comparison pulse timer
  //--------------------------------------------------------------------
  logic [SW-1:0]     step_cnt_r;
  logic [PDUR_W-1:0] steps_left_r;
  logic              pls_r;
  logic              step_end;

  assign step_end = step_cnt_r == SW'(STEP_CYC - 1);
  assign pulse_on = pls_r;

  // a trigger during a running pulse is ignored, so it never stretches
  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      step_cnt_r   <= '0;
      steps_left_r <= '0;
      pls_r        <= 1'b0;
    end else if (!pls_r) begin
      if (fire) begin
        pls_r        <= 1'b1;
        steps_left_r <= PULSE_DUR_IN;
        step_cnt_r   <= '0;
      end
    end else if (step_end) begin
      step_cnt_r   <= '0;
      steps_left_r <= steps_left_r - 1'b1;
      if (steps_left_r == PDUR_W'(1)) begin
        pls_r <= 1'b0;
      end
    end else begin
      step_cnt_r <= step_cnt_r + 1'b1;
    end
  end

  assign COMPARE_OUT = (cmp_mode == CMP_PULSE && !pdur_zero) ? pulse_on : out_r;

  //--------------------------------------------------------------------
  // integration time and job interface
  //--------------------------------------------------------------------
  logic [INTEG_W-1:0] integ_r;
  logic               cfg_ld_r;
  logic               job_prev_r;
  logic               job_done_r;
  logic               job_err_r;
  logic [15:0]        job_stat_r;
  logic [31:0]        job_oval_r;
  logic               job_edge;
  logic               val_low;
  logic               val_high;
  logic [15:0]        stat_nxt;

  assign job_edge = JOB_REQ_IN & ~job_prev_r;
  assign val_low  = $signed(JOB_VAL_IN) < $signed({18'h0, INTEG_MIN_MS});
  assign val_high = $signed(JOB_VAL_IN) > $signed({18'h0, INTEG_MAX_MS});
  assign stat_nxt = (JOB_ID_IN == JOB_NOP || JOB_ID_IN == JOB_RD_INTEG) ? STAT_OK :
                    (JOB_ID_IN != JOB_WR_INTEG) ? STAT_BAD_JOB :
                    val_low ? STAT_INTEG_LOW :
                    val_high ? STAT_INTEG_HIGH : STAT_OK;

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      integ_r    <= INTEG_MIN_MS;
      cfg_ld_r   <= 1'b0;
      job_prev_r <= 1'b0;
      job_done_r <= 1'b1;
      job_err_r  <= 1'b0;
      job_stat_r <= STAT_OK;
      job_oval_r <= 32'h0000_0000;
    end else begin
      job_prev_r <= JOB_REQ_IN;
      job_done_r <= ~job_edge;
      cfg_ld_r   <= 1'b1;
      // the configured time is taken once, on the first edge after reset
      if (!cfg_ld_r) begin
        integ_r <= INTEG_CFG_IN;
      end else if (job_edge) begin
        job_err_r  <= stat_nxt != STAT_OK;
        job_stat_r <= stat_nxt;
        if (JOB_ID_IN == JOB_WR_INTEG && stat_nxt == STAT_OK) begin
          integ_r <= JOB_VAL_IN[INTEG_W-1:0];
        end
        if (JOB_ID_IN == JOB_RD_INTEG) begin
          job_oval_r <= {18'h0, integ_r};
        end
      end
    end
  end

  assign JOB_DONE_OUT = job_done_r;
  assign JOB_ERR_OUT  = job_err_r;
  assign JOB_STAT_OUT = job_stat_r;
  assign JOB_OVAL_OUT = job_oval_r;

  //--------------------------------------------------------------------
  // frequency meter
  //--------------------------------------------------------------------
  chf_fm_state_t      fm_r;
  logic [TW-1:0]      tick_r;
  logic [INTEG_W-1:0] ms_r;
  logic [INTEG_W-1:0] act_r;
  logic [CNT_W-1:0]   pcnt_r;
  logic [CNT_W-1:0]   meas_r;
  logic               gate;
  logic               tick_end;
  logic               ivl_done;
  logic [CNT_W-1:0]   pcnt_fin;
  logic               div_done;
  logic [CNT_W-1:0]   div_q;

  assign gate     = SOFTWARE_GATE_BIT_IN & FREQ_MODE_IN;
  assign tick_end = tick_r == TW'(TICK_CYC - 1);
  assign ivl_done = fm_r == FM_MEASURE && gate && tick_end && ms_r == act_r - 1'b1;
  // an edge in the closing cycle still belongs to this interval
  assign pcnt_fin = (b_rise && pcnt_r != '1) ? pcnt_r + 1'b1 : pcnt_r;

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      fm_r   <= FM_IDLE;
      tick_r <= '0;
      ms_r   <= '0;
      act_r  <= INTEG_MIN_MS;
      pcnt_r <= '0;
    end else begin
      unique case (fm_r)
        FM_IDLE: begin
          tick_r <= '0;
          ms_r   <= '0;
          pcnt_r <= '0;
          act_r  <= integ_r;
          if (gate) begin
            fm_r <= FM_MEASURE;
          end
        end
        FM_MEASURE: begin
          if (!gate) begin
            fm_r <= FM_IDLE;
          end else if (ivl_done) begin
            tick_r <= '0;
            ms_r   <= '0;
            pcnt_r <= '0;
            act_r  <= integ_r;
          end else begin
            pcnt_r <= pcnt_fin;
            tick_r <= tick_end ? '0 : tick_r + 1'b1;
            ms_r   <= tick_end ? ms_r + 1'b1 : ms_r;
          end
        end
      endcase
    end
  end

  chf_mhz_div #(
    .CW (CNT_W),
    .DW (INTEG_W)
  ) u_div (
    .clk    (REF_CLK_IN),
    .rst_n  (RESET_N_IN),
    .start  (ivl_done),
    .pulses (pcnt_fin),
    .ms     (act_r),
    .done   (div_done),
    .quot   (div_q)
  );

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      meas_r <= MEAS_RST;
    end else if (div_done) begin
      meas_r <= div_q;
    end
  end

  assign MEASURED_FREQUENCY_VALUE_OUT = meas_r;
  assign GATE_STATUS_OUT              = fm_r == FM_MEASURE;

  //--------------------------------------------------------------------
  // end of measurement interrupt
  //--------------------------------------------------------------------
  chf_irq_sel_t irq_sel;
  logic         irq_pend_r;
  logic         hw_irq_r;
  logic         diag_irq_r;
  logic         irq_fire;

  assign irq_sel  = chf_irq_sel_t'(IRQ_SEL_IN);
  // code 2'b11 is not a legal choice and raises nothing
  assign irq_fire = ivl_done & EOM_IRQ_EN_IN &
                    (irq_sel == IRQ_PROC || irq_sel == IRQ_DIAG_PROC);

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      irq_pend_r <= 1'b0;
      hw_irq_r   <= 1'b0;
      diag_irq_r <= 1'b0;
    end else begin
      hw_irq_r   <= irq_fire;
      diag_irq_r <= irq_fire & irq_pend_r & (irq_sel == IRQ_DIAG_PROC);
      // a new interrupt wins over an acknowledge in the same cycle
      irq_pend_r <= irq_fire | (irq_pend_r & ~IRQ_ACK_IN);
    end
  end

  assign HW_IRQ_OUT   = hw_irq_r;
  assign DIAG_IRQ_OUT = diag_irq_r;
endmodule // chf_counter_channel

// file: chf_counter_channel_asserts.sv
`timescale 1ns/1ps
module chf_counter_channel_asserts
  import chf_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYCLES,
  parameter int unsigned STEP_CYC = PULSE_STEP_CYCLES
) (
  input wire logic              REF_CLK_IN,
  input wire logic              RESET_N_IN,
  input wire logic              FREQ_MODE_IN,
  input wire logic [1:0]        CMP_MODE_IN,
  input wire logic [CNT_W-1:0]  CMP_VALUE_IN,
  input wire logic [HYST_W-1:0] HYST_IN,
  input wire logic [PDUR_W-1:0] PULSE_DUR_IN,
  input wire logic              SOFTWARE_GATE_BIT_IN,
  input wire logic              EOM_IRQ_EN_IN,
  input wire logic [1:0]        IRQ_SEL_IN,
  input wire logic              JOB_REQ_IN,
  input wire logic              JOB_DONE_OUT,
  input wire logic              JOB_ERR_OUT,
  input wire logic [15:0]       JOB_STAT_OUT,
  input wire logic              COMPARE_OUT,
  input wire logic [CNT_W-1:0]  COUNT_VALUE_OUT,
  input wire logic              GATE_STATUS_OUT,
  input wire logic              HW_IRQ_OUT,
  input wire logic              DIAG_IRQ_OUT
);
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  logic [31:0] hi_r;
  // ----------------
  // pulse width meter
  // ----------------
  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      hi_r <= 32'h0;
    end else begin
      hi_r <= COMPARE_OUT ? hi_r + 32'h1 : 32'h0;
    end
  end
  // the first edge after release only loads config, so a job there is not taken
  sequence s_job_take;
    $rose(JOB_REQ_IN) && $past(RESET_N_IN) && JOB_DONE_OUT;
  endsequence
  sequence s_job_ack;
    !JOB_DONE_OUT ##1 JOB_DONE_OUT;
  endsequence
  sequence s_gate_up;
    $rose(SOFTWARE_GATE_BIT_IN && FREQ_MODE_IN);
  endsequence
  property p_job_done;
    s_job_take |=> s_job_ack;
  endproperty
  a_job_done: assert property (p_job_done) else $error("job done");
  property p_job_err;
    JOB_ERR_OUT == (JOB_STAT_OUT != 16'h0000);
  endproperty
  a_job_err: assert property (p_job_err) else $error("job err");
  property p_freq_hold;
    FREQ_MODE_IN [*4] |-> $stable(COUNT_VALUE_OUT) && !COMPARE_OUT;
  endproperty
  a_freq_hold: assert property (p_freq_hold) else $error("freq hold");
  property p_gate_open;
    s_gate_up |=> GATE_STATUS_OUT;
  endproperty
  a_gate_open: assert property (p_gate_open) else $error("gate open");
  property p_irq_cause;
    HW_IRQ_OUT |-> EOM_IRQ_EN_IN && IRQ_SEL_IN inside {2'b01, 2'b10} ##1 !HW_IRQ_OUT;
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq cause");
  property p_diag;
    DIAG_IRQ_OUT |-> HW_IRQ_OUT && IRQ_SEL_IN == 2'b10;
  endproperty
  a_diag: assert property (p_diag) else $error("diag irq");
  property p_ge_off;
    (CMP_MODE_IN == 2'b01 && HYST_IN < 8'h02 && !FREQ_MODE_IN) [*2] |=>
      COMPARE_OUT == ($signed($past(COUNT_VALUE_OUT)) >= $signed(CMP_VALUE_IN));
  endproperty
  a_ge_off: assert property (p_ge_off) else $error("ge level");
  property p_pulse_len;
    $fell(COMPARE_OUT) && CMP_MODE_IN == 2'b11 && PULSE_DUR_IN != 8'h00 |->
      hi_r == PULSE_DUR_IN * STEP_CYC;
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("pulse length");
endmodule // chf_counter_channel_asserts

bind chf_counter_channel chf_counter_channel_asserts #(
  .TICK_CYC(TICK_CYC),
  .STEP_CYC(STEP_CYC)
) u_chk (.*);

// file: chf_pulse_src.sv
`timescale 1ns/1ps
module chf_pulse_src #(
  parameter int HALF = 7
) (
  input  wire logic clk_in,
  input  wire logic run_in,
  output logic      sig_out = 1'b0
);
  int cnt_r = 0;
  // ----------------
  // field line
  // ----------------
  // idles low between bursts, as a pulled-down input would
  always @(posedge clk_in) begin
    if (!run_in || cnt_r == HALF - 1) begin
      cnt_r <= 0;
    end else begin
      cnt_r <= cnt_r + 1;
    end
    sig_out <= #1 run_in && (cnt_r == HALF - 1 ? !sig_out : sig_out);
  end
endmodule // chf_pulse_src

// file: counter_hysteresis_freq_meter_tb.sv
`timescale 1ns/1ps
module counter_hysteresis_freq_meter_tb;
  localparam int TK = 8;
  localparam int CV = 4;
  logic        clk, rst_n, a_r, dir_r, fm, gate, eom, jreq, run, pq, sq, src, ack, s1, s2;
  logic        jdone, jerr, cmpo, gst, hwi, dgi;
  logic [1:0]  md, sel;
  logic [7:0]  hy, dur;
  logic [15:0] jid, jstat;
  logic [31:0] jval, joval, cntv, meas, lfsr;
  int          fails, checks, cyc, c, hyi, pls, npl, ndg, es, ls, lc, n, ms;
  bit          arm, out, pc, sd;

  always #12.5 clk = ~clk;
  chf_counter_channel #(.TICK_CYC(TK), .STEP_CYC(16)) DUT (
    .REF_CLK_IN(clk), .RESET_N_IN(rst_n), .CH_A_IN(a_r | src),
    .CH_B_IN(fm ? src : dir_r), .FREQ_MODE_IN(fm), .CMP_MODE_IN(md),
    .CMP_VALUE_IN(32'h4), .HYST_IN(hy), .PULSE_DUR_IN(dur), .SOFTWARE_GATE_BIT_IN(gate),
    .INTEG_CFG_IN(14'h000C), .EOM_IRQ_EN_IN(eom), .IRQ_SEL_IN(sel), .IRQ_ACK_IN(ack),
    .JOB_REQ_IN(jreq), .JOB_ID_IN(jid), .JOB_VAL_IN(jval), .JOB_DONE_OUT(jdone),
    .JOB_ERR_OUT(jerr), .JOB_STAT_OUT(jstat), .JOB_OVAL_OUT(joval), .COMPARE_OUT(cmpo),
    .COUNT_VALUE_OUT(cntv), .GATE_STATUS_OUT(gst), .MEASURED_FREQUENCY_VALUE_OUT(meas),
    .HW_IRQ_OUT(hwi), .DIAG_IRQ_OUT(dgi));
  chf_pulse_src u_src (.clk_in(clk), .run_in(run), .sig_out(src));

  always @(posedge clk) begin
    pq <= cmpo;
    // edges are counted two clocks late, in step with the pin synchroniser
    s1 <= src;
    s2 <= s1;
    sq <= s2;
    cyc <= cyc + 1;
    if (cmpo === 1'b1 && pq === 1'b0) npl <= npl + 1;
    if (s2 === 1'b1 && sq === 1'b0) es <= es + 1;
    if (dgi === 1'b1) ndg <= ndg + 1;
    if (cyc == 20000) begin
      fails++;
      test_done;
    end
  end
  // ----------------
  // tasks
  // ----------------
  task automatic test_done;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] v);
    checks++;
    if (v !== e) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", s, e, v);
    end
  endtask
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic cy(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic rst;
    rst_n = 1'b0;
    cy(3);
    rst_n = 1'b1;
    {c, arm, out, pc, pls, npl} = '0;
    // le mode arms at count 0 and leaves the window at once
    repeat (2) upd(1);
    cy(2);
  endtask
  task automatic upd(input bit up);
    bit cnd, hi, ex;
    cnd = (md == 2'b01) ? (c >= CV) : (md == 2'b10) ? (c <= CV) : (c == CV);
    hi = c > CV + hyi;
    ex = hi || c < CV - hyi;
    if (arm && ex) begin
      arm = 0;
      out = (md != 2'b11) && cnd;
      if (md == 2'b11 && hi != sd) pls++;
    end else if (arm) begin
      if (md != 2'b11 && !cnd) out = 0;
    end else begin
      if (cnd && !pc) begin
        arm = hyi > 1;
        sd = up;
        if (md == 2'b11) pls++;
      end
      out = cnd;
    end
    pc = cnd;
  endtask
  // direction is set ahead of the count edge so both cross the synchroniser apart
  task automatic step(input bit up);
    dir_r = up;
    cy(2);
    a_r = 1'b1;
    cy(3);
    a_r = 1'b0;
    cy(15);
    c = up ? c + 1 : c - 1;
    upd(up);
    chk("count", c, cntv);
    if (md == 2'b11 && dur != 8'h00) chk("pulses", pls, npl);
    else chk("compare", out, cmpo);
  endtask
  task automatic jb(input logic [15:0] id, input logic [31:0] v, input logic [15:0] st);
    jid = id;
    jval = v;
    jreq = 1'b1;
    cy(1);
    chk("job done", 0, jdone);
    chk("job stat", st, jstat);
    chk("job err", st != 16'h0000, jerr);
    jreq = 1'b0;
    cy(1);
    chk("job idle", 1, jdone);
  endtask
  task automatic wirq;
    for (int i = 0; i < 400 && hwi !== 1'b1; i++) cy(1);
  endtask

  initial begin
    {clk, rst_n, a_r, dir_r, fm, eom, jreq, run, pq, sq, md, sel, hy, dur, ack, s1, s2} = '0;
    {jid, jval, fails, checks, cyc, es, ndg, ls, lc} = '0;
    gate = 1'b1;
    lfsr = 32'hD2FA9576;
    for (int m = 0; m < 5; m++) begin
      md = (m == 4) ? 2'b10 : (m % 3 == 0) ? 2'b01 : 2'b11;
      hyi = (m == 3) ? 0 : 3;
      hy = hyi[7:0];
      dur = (m == 2) ? 8'h01 : 8'h00;
      rst;
      repeat (60) begin
        lfsr = nxt(lfsr);
        step((c < 0) || (c < 9 && lfsr[0]));
      end
      $display("comparator test %0d done", m);
    end
    jb(16'h0084, 32'h0, 16'h0000);
    chk("job read", 32'hC, joval);
    jb(16'h0004, 32'h2710, 16'h0000);
    jb(16'h0004, 32'h9, 16'h0221);
    jb(16'h0004, 32'h2711, 16'h0222);
    jb(16'h0001, 32'h0, 16'h02FF);
    jb(16'h0000, 32'h0, 16'h0000);
    jb(16'h0084, 32'h0, 16'h0000);
    chk("job read", 32'h2710, joval);
    jb(16'h0004, 32'h14, 16'h0000);
    $display("job test done");
    fm = 1'b1;
    eom = 1'b1;
    sel = 2'b10;
    run = 1'b1;
    cy(2);
    chk("gate", 1, gst);
    chk("freq", 0, meas);
    for (int k = 0; k < 6; k++) begin
      wirq;
      n = es - ls;
      ms = (cyc - lc) / TK;
      ls = es;
      lc = cyc;
      run = (k < 3);
      ack = (k == 2);
      cy(60);
      if (k > 0) begin
        chk("interval", 20, ms);
        chk("freq", n * 1000000 / ms, meas);
      end
    end
    chk("diag", 4, ndg);
    chk("count", c, cntv);
    gate = 1'b0;
    cy(300);
    chk("gate", 0, gst);
    chk("freq", n * 1000000 / ms, meas);
    $display("frequency test done");
    test_done;
  end
endmodule // counter_hysteresis_freq_meter_tb
